// File: rtl/decade_johnson_counter.sv
// Purpose: divide-by-ten johnson counter with ten decoded slots
// Assumes: count_clk, clear and hold_n arrive from pins, sampled on clock
// Notes: a rising edge of count_clk is one count event
`timescale 1ns/100ps
`default_nettype none
`include "decade_johnson_counter_regs.svh"
module decade_johnson_counter (
   input  wire logic                                  clock,
   input  wire logic                                  nrst,
   input  wire logic                                  count_clk,
   input  wire logic                                  clear,
   input  wire logic                                  hold_n,
   output var  decade_johnson_counter_pkg::count_out_t outs
);
   logic                              clk_s;
   logic                              clear_s;
   logic                              hold_s;
   logic                              clk_d_r;
   logic                              step;
   decade_johnson_counter_pkg::ring_t ring_r;
   decade_johnson_counter_pkg::ring_t ring_nxt;
   logic [3:0]                        cnt_nxt;
   logic [3:0]                        lap_r;
   logic [3:0]                        lap_nxt;

   // pin synchronisers
   pin_sync #(.RESET_VAL(1'b0)) u_clk_sync (
      .clock (clock),
      .nrst  (nrst),
      .pin   (count_clk),
      .level (clk_s)
   );
   pin_sync #(.RESET_VAL(1'b1)) u_clr_sync (
      .clock (clock),
      .nrst  (nrst),
      .pin   (clear),
      .level (clear_s)
   );
   pin_sync #(.RESET_VAL(1'b1)) u_hold_sync (
      .clock (clock),
      .nrst  (nrst),
      .pin   (hold_n),
      .level (hold_s)
   );

   // maps a johnson state to its count 0..9
   function automatic logic [3:0] ring_count(decade_johnson_counter_pkg::ring_t r);
      logic [3:0] c;
      c = 4'h0;
      unique case (r)
         5'h00:   c = 4'h0;
         5'h01:   c = 4'h1;
         5'h03:   c = 4'h2;
         5'h07:   c = 4'h3;
         5'h0f:   c = 4'h4;
         5'h1f:   c = 4'h5;
         5'h1e:   c = 4'h6;
         5'h1c:   c = 4'h7;
         5'h18:   c = 4'h8;
         5'h10:   c = 4'h9;
         default: c = 4'h0;
      endcase
      return c;
   endfunction : ring_count

   // edge detect on the synchronised count clock
   always_ff @(posedge clock or negedge nrst) begin
      if (!nrst) begin
         clk_d_r <= 1'b0;
      end else begin
         clk_d_r <= clk_s;
      end
   end

   assign step = clk_s & ~clk_d_r & ~hold_s;

   // twisted ring shift; illegal states self-correct to zero
   always_comb begin
      ring_nxt = {ring_r[`JC_STAGES-2:0], ~ring_r[`JC_STAGES-1]};
      if (ring_count(ring_r) == 4'h0 && ring_r != `JC_RING_RESET) begin
         ring_nxt = `JC_RING_RESET;
      end
   end

   // count register
   always_ff @(posedge clock or negedge nrst) begin
      if (!nrst) begin
         ring_r <= `JC_RING_RESET;
      end else if (clear_s) begin
         ring_r <= `JC_RING_RESET;
      end else if (step) begin
         ring_r <= ring_nxt;
      end
   end

   // decoded outputs registered so they cannot glitch
   always_comb begin
      cnt_nxt = ring_count(ring_nxt);
   end

   always_ff @(posedge clock or negedge nrst) begin
      if (!nrst) begin
         outs.slot  <= `JC_SLOT_RESET;
         outs.carry <= 1'b1;
      end else if (clear_s) begin
         outs.slot  <= `JC_SLOT_RESET;
         outs.carry <= 1'b1;
      end else if (step) begin
         outs.slot  <= `JC_SLOTS'(1) << cnt_nxt;
         outs.carry <= (cnt_nxt < 4'h5);
      end
   end

   // independent tally of accepted steps, wraps after ten; read by assertions only
   always_comb begin
      lap_nxt = lap_r + 4'h1;
      if (lap_r == 4'(`JC_SLOTS - 1)) begin
         lap_nxt = 4'h0;
      end
   end

   always_ff @(posedge clock or negedge nrst) begin
      if (!nrst) begin
         lap_r <= 4'h0;
      end else if (clear_s) begin
         lap_r <= 4'h0;
      end else if (step) begin
         lap_r <= lap_nxt;
      end
   end

   // a synchronised count edge that the counter accepts
   sequence count_edge_s;
      clk_s && !clk_d_r && !hold_s && !clear_s;
   endsequence

   // a synchronised count edge that arrives while held
   sequence held_edge_s;
      clk_s && !clk_d_r && hold_s && !clear_s;
   endsequence

   // last slot about to hand over to slot zero
   sequence wrap_edge_s;
      count_edge_s ##0 outs.slot[`JC_SLOTS-1];
   endsequence

   // slot four about to hand over to slot five
   sequence half_edge_s;
      count_edge_s ##0 outs.slot[4];
   endsequence

   // one-hot slot outputs
   one_hot_a: assert property (@(posedge clock) disable iff (!nrst)
      $onehot(outs.slot))
      else $error("slot outputs not one-hot");

   // clear drives count zero
   clear_zero_a: assert property (@(posedge clock) disable iff (!nrst)
      clear_s |=> outs.slot == `JC_SLOT_RESET && outs.carry)
      else $error("clear did not force count zero");

   // hold freezes outputs
   hold_freeze_a: assert property (@(posedge clock) disable iff (!nrst)
      hold_s && !clear_s |=> $stable(outs))
      else $error("outputs moved while held");

   // advance moves to next slot
   advance_a: assert property (@(posedge clock) disable iff (!nrst)
      step && !clear_s |=> outs.slot == {$past(outs.slot[8:0]), $past(outs.slot[9])})
      else $error("slot did not rotate");

   // slot holds between steps
   slot_stable_a: assert property (@(posedge clock) disable iff (!nrst)
      !step && !clear_s |=> $stable(outs.slot))
      else $error("slot changed without a step");

   // carry tied to slot position
   carry_map_a: assert property (@(posedge clock) disable iff (!nrst)
      outs.carry == (|outs.slot[4:0]))
      else $error("carry disagrees with slot");

   // carry rises only into slot zero
   carry_rise_a: assert property (@(posedge clock) disable iff (!nrst)
      $rose(outs.carry) |-> outs.slot[0])
      else $error("carry rose outside count zero");

   // ring stays in legal johnson states
   ring_legal_a: assert property (@(posedge clock) disable iff (!nrst)
      ring_count(ring_r) != 4'h0 || ring_r == `JC_RING_RESET)
      else $error("ring in illegal state");

   // accepted count edge moves the ring
   ring_moves_a: assert property (@(posedge clock) disable iff (!nrst)
      count_edge_s |=> ring_r != $past(ring_r))
      else $error("accepted count edge did not move the ring");

   // count edge while held leaves the ring alone
   held_edge_a: assert property (@(posedge clock) disable iff (!nrst)
      held_edge_s |=> $stable(ring_r))
      else $error("held count edge moved the ring");

   // leaving the last slot wraps to zero and raises carry
   wrap_carry_a: assert property (@(posedge clock) disable iff (!nrst)
      wrap_edge_s |=> outs.slot[0] && $rose(outs.carry))
      else $error("wrap did not raise carry at count zero");

   // leaving slot four drops carry into slot five
   half_carry_a: assert property (@(posedge clock) disable iff (!nrst)
      half_edge_s |=> outs.slot[5] && $fell(outs.carry))
      else $error("carry did not fall entering count five");

   // decoded slot agrees with the ring state
   slot_ring_a: assert property (@(posedge clock) disable iff (!nrst)
      outs.slot == (`JC_SLOTS'(1) << ring_count(ring_r)))
      else $error("slot outputs disagree with ring");

   // ring follows the independent step tally
   lap_track_a: assert property (@(posedge clock) disable iff (!nrst)
      ring_count(ring_r) == lap_r)
      else $error("ring count lost track of steps");

   // the lit slot is the one the step tally names
   lap_slot_a: assert property (@(posedge clock) disable iff (!nrst)
      outs.slot[lap_r])
      else $error("lit slot disagrees with step tally");
endmodule : decade_johnson_counter
`default_nettype wire

// File: rtl/decade_johnson_counter_pkg.sv
// Purpose: types for the decade johnson counter
// Assumes: constants header is included alongside
// Notes: none
`include "decade_johnson_counter_regs.svh"
package decade_johnson_counter_pkg;
   typedef logic [`JC_STAGES-1:0] ring_t;
   typedef logic [`JC_SLOTS-1:0]  slot_t;
   typedef struct packed {
      slot_t slot;
      logic  carry;
   } count_out_t;
endpackage : decade_johnson_counter_pkg

// File: rtl/decade_johnson_counter_regs.svh
// Purpose: constants for the decade johnson counter
// Assumes: one 40 MHz clock, active low asynchronous reset
// Notes: state is a five stage twisted ring
//
// Summary of operation
// - five-stage johnson ring, ten slots, carry
// - clear input high forces count zero
// - advance on clock only when enable low
// - exactly one slot output high per state
// - each slot high one full count period
// - carry completes one period per ten counts
// - glitch-free: outputs registered, no decode hazards
`ifndef DECADE_JOHNSON_COUNTER_REGS_SVH
`define DECADE_JOHNSON_COUNTER_REGS_SVH
`define JC_STAGES      5
`define JC_SLOTS       10
`define JC_RING_RESET  5'h00
`define JC_SLOT_RESET  10'h001
`define JC_SYNC_DEPTH  3
`endif

// File: rtl/pin_sync.sv
// Purpose: three flop pin synchroniser with agreement check
// Assumes: pin is asynchronous to clock
// Notes: first flop feeds only the second
`timescale 1ns/100ps
`default_nettype none
module pin_sync #(
   parameter logic RESET_VAL = 1'b0
) (
   input  wire logic clock,
   input  wire logic nrst,
   input  wire logic pin,
   output var  logic level
);
   logic meta_r;
   logic s2_r;
   logic s3_r;

   // three flop chain
   always_ff @(posedge clock or negedge nrst) begin
      if (!nrst) begin
         meta_r <= RESET_VAL;
         s2_r   <= RESET_VAL;
         s3_r   <= RESET_VAL;
      end else begin
         meta_r <= pin;
         s2_r   <= meta_r;
         s3_r   <= s2_r;
      end
   end

   // accept a change once the last two agree
   always_ff @(posedge clock or negedge nrst) begin
      if (!nrst) begin
         level <= RESET_VAL;
      end else if (s2_r == s3_r) begin
         level <= s3_r;
      end
   end
endmodule : pin_sync
`default_nettype wire

// File: testbench/count_source.sv
// Purpose: count clock source standing before the counter
// Assumes: phases long against the synchroniser
// Notes: each phase lasts four to seven clocks at random
`timescale 1ns/100ps
`default_nettype none
module count_source (
   input  wire logic clock,
   output var  logic count_clk
);
   initial count_clk = 1'b0;
   // one count event, low phase then high phase
   task automatic tick();
      repeat (4 + $urandom_range(3)) @(posedge clock);
      count_clk <= 1'b1;
      repeat (4 + $urandom_range(3)) @(posedge clock);
      count_clk <= 1'b0;
   endtask : tick
endmodule : count_source
`default_nettype wire

// File: testbench/tb.sv
// Purpose: self-checking bench for the decade johnson counter
// Assumes: integer count model, checked after every count event
// Notes: slot and carry coherence watched every cycle
`timescale 1ns/100ps
`default_nettype none
module tb;
   logic clock, nrst, clear, hold_n, run;
   wire logic count_clk;
   decade_johnson_counter_pkg::count_out_t outs, exp;
   int mismatches, total_checks, cnt;
   decade_johnson_counter i_dut (.clock(clock), .nrst(nrst), .count_clk(count_clk),
      .clear(clear), .hold_n(hold_n), .outs(outs));
   count_source i_src (.clock(clock), .count_clk(count_clk));
   // 40 mhz clock
   initial clock = 1'b0;
   always #12.5 clock = ~clock;
   // compare outputs with the model count
   task automatic compare();
      exp.slot = 10'h001 << cnt;
      exp.carry = (cnt < 5);
      total_checks++;
      if (outs !== exp) begin
         mismatches++;
         $display("CHECK FAILED t=%0t got=%h exp=%h", $time, outs, exp);
      end
   endtask : compare
   // one count event, model advances only when enabled and not cleared
   task automatic step();
      i_src.tick();
      repeat (3) @(posedge clock);
      if (hold_n === 1'b0 && clear === 1'b0) cnt = (cnt + 1) % 10;
      compare();
   endtask : step
   // one hot slot, carry tied to slots zero-four, every cycle
   always @(negedge clock) if (run) begin
      total_checks++;
      if ($isunknown(outs) || !$onehot(outs.slot) || outs.carry !== |outs.slot[4:0]) begin
         mismatches++;
         $display("CHECK FAILED t=%0t got=%h exp=%h", $time, outs, {outs.slot, |outs.slot[4:0]});
      end
   end
   task automatic print_verdict();
      $display("checks=%0d mismatches=%0d", total_checks, mismatches);
      if (mismatches == 0 && total_checks > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask : print_verdict
   // watchdog against a hang
   initial begin
      #200us;
      mismatches++;
      print_verdict();
   end
   initial begin
      nrst = 1'b0; clear = 1'b0; hold_n = 1'b0; run = 1'b0;
      cnt = 0; mismatches = 0; total_checks = 0;
      void'($urandom(32'h6c65));
      repeat (20) @(posedge clock);
      nrst <= 1'b1;
      repeat (6) @(posedge clock);
      run <= 1'b1;
      compare();
      $display("test reset done");
      // random holds over two and a half carry periods
      for (int i = 0; i < 25; i++) begin
         hold_n <= ($urandom_range(3) == 0);
         repeat (6) @(posedge clock);
         step();
      end
      $display("test count done");
      // clear mid-sequence wins over a count event
      hold_n <= 1'b0;
      repeat (6) @(posedge clock);
      step();
      if (cnt == 0) step();
      clear <= 1'b1;
      repeat (6) @(posedge clock);
      cnt = 0;
      compare();
      step();
      clear <= 1'b0;
      repeat (6) @(posedge clock);
      step();
      $display("test clear done");
      // second reset mid-run
      nrst <= 1'b0;
      repeat (2) @(posedge clock);
      cnt = 0;
      compare();
      nrst <= 1'b1;
      repeat (6) @(posedge clock);
      step();
      $display("test rereset done");
      print_verdict();
   end
endmodule : tb
`default_nettype wire
